/* reset_cause_pkg.sv */
// Shared constants for the reset-cause recording block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
package reset_cause_pkg;

	// ************************************************************
	// Register indices; the byte address is four times the index.
	// ************************************************************
	localparam logic [11:0] IDX_BROWNOUT_CONTROL = 12'h811;
	localparam logic [11:0] IDX_RESET_CAUSE = 12'h813;
	localparam logic [11:0] IDX_VIOLATION_CAUSE = 12'h814;
	localparam logic [11:0] IDX_CORE_STATUS = 12'h815;
	localparam logic [11:0] IDX_RESET_CONFIG = 12'h816;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int BIT_SW_BOR_EN = 7;
	localparam int BIT_BOR_READY = 0;
	localparam int BIT_STK_OVF = 7;
	localparam int BIT_STK_UNF = 6;
	localparam int BIT_WDT_N = 4;
	localparam int BIT_PIN_N = 3;
	localparam int BIT_INSTR_N = 2;
	localparam int BIT_POR_N = 1;
	localparam int BIT_BOR_N = 0;
	localparam int BIT_MEM_VIOLATION_FLAG_N_N = 1;
	localparam int BIT_TIMEOUT = 1;
	localparam int BIT_POWERDOWN = 0;
	localparam int BIT_CFG_MODE_LO = 0;
	localparam int BIT_CFG_STACK_ERROR_RESET_ENABLE = 2;
	localparam int BIT_CFG_SAF_EN = 3;

	// ************************************************************
	// Encodings and reset values.
	// ************************************************************
	localparam logic [1:0] BOR_MODE_ON = 2'h3;
	localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
	localparam logic [1:0] BOR_MODE_SW = 2'h1;
	localparam logic [1:0] RST_BOR_MODE = 2'h1;
	localparam logic RST_STACK_ERROR_RESET_ENABLE = 1'b1;
	localparam logic RST_SAF_EN = 1'b0;
	localparam logic RST_BOR_FLAG_N = 1'b1;
	localparam logic [14:0] IRQ_VECTOR = 15'h0004;
	localparam logic [14:0] RESET_VECTOR = 15'h0000;

	typedef enum logic [1:0] {
		WAKE_IDLE = 2'b00,
		WAKE_RESUME = 2'b01,
		WAKE_VECTOR = 2'b11
	} wake_e;

endpackage

/* reset_cause_flags.sv */
// Reset-cause flags, brown-out control and memory execution guard.
// Assumes event inputs are one-cycle pulses on clock; the reset pin and
// the brown-out ready level come from outside and are synchronised here.

// Overview of operation
// - Fetch beyond program memory or into enabled protected flash raises reset.
// - Each reset other than power-on or brown-out updates only the flag of its own cause.
// - Hardware makes a flag inactive only on power-on or brown-out; software may.
// - Software writing a flag active stores it and causes no reset.
// - Software brown-out enable, bit 7, acts only when mode equals 01.
// - Brown-out ready reads 1 only when circuit is active and armed.
// - Stack overflow flag, bit 7, set by too many calls.
// - Stack underflow flag, bit 6, set by too many returns.
// - Watchdog flag, bit 4, cleared by watchdog overflow reset.
// - Pin flag, bit 3, cleared by external pin reset.
// - Instruction flag, bit 2, cleared by reset instruction.
// - Power-on flag, bit 1, cleared by power-on reset.
// - Brown-out flag, bit 0, cleared by brown-out reset.
// - Violation flag cleared by violation reset, one after power-on.
// - Power-on or brown-out sets the documented flag and enable defaults.
// - Power-on sets time-out and power-down; watchdog clears time-out.
// - Any wake clears power-down; pin reset in sleep sets time-out.
// - Wake resumes at next address; an interrupt wake then vectors to 0004h if enabled.
// - Every true reset source loads program counter with zero.
// - Brown-out detection follows software enable only in mode 01.
// - Stack errors reset only while stack-error reset enable is set.
module reset_cause_flags
	import reset_cause_pkg::*;
#(
	parameter int PROG_WORDS = 4096,
	parameter int SAF_BASE = 3968
)
(
	// Clock and block reset.
	input wire logic clock,
	input wire logic rst,
	// Avalon-MM slave.
	input wire logic [13:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Reset sources.
	input wire logic por_event,
	input wire logic bor_event,
	input wire logic external_reset_pin_n,
	input wire logic watchdog_timeout,
	input wire logic reset_instr,
	input wire logic stack_overflow_evt,
	input wire logic stack_underflow_evt,
	// Core execution and sleep.
	input wire logic fetch_exec,
	input wire logic [14:0] fetch_addr,
	input wire logic sleep_active,
	input wire logic irq_wake,
	input wire logic global_irq_enable,
	// Brown-out circuit.
	input wire logic brownout_ready_raw,
	output logic brownout_detect_en,
	// Results.
	output logic device_reset,
	output logic pc_load,
	output logic [14:0] pc_load_addr,
	output logic wake_resume,
	output logic irq_push,
	output logic timeout_status,
	output logic powerdown_status
);

	// ************************************************************
	// State.
	// ************************************************************
	typedef struct packed {
		logic [1:0] pin_sync;
		logic pin_prev;
		logic [1:0] rdy_sync;
		logic ack;
		logic [31:0] rdata;
		logic sw_brownout_enable;
		logic stack_overflow_flag;
		logic stack_underflow_flag;
		logic watchdog_reset_flag_n;
		logic pin_reset_flag_n;
		logic instr_reset_flag_n;
		logic por_flag_n;
		logic brownout_flag_n;
		logic mem_violation_flag_n;
		logic timeout_status;
		logic powerdown_status;
		logic [1:0] brownout_mode_cfg;
		logic stack_error_reset_enable;
		logic saf_enable;
		logic dev_reset;
		logic pc_load;
		logic [14:0] pc_addr;
		logic irq_woke;
		wake_e wake;
	} state_s;

	localparam state_s ST_RESET = '{
		pin_sync: 2'b11,
		pin_prev: 1'b1,
		rdy_sync: 2'b00,
		ack: 1'b0,
		rdata: 32'h0000_0000,
		sw_brownout_enable: 1'b1,
		stack_overflow_flag: 1'b0,
		stack_underflow_flag: 1'b0,
		watchdog_reset_flag_n: 1'b1,
		pin_reset_flag_n: 1'b1,
		instr_reset_flag_n: 1'b1,
		por_flag_n: 1'b0,
		brownout_flag_n: RST_BOR_FLAG_N,
		mem_violation_flag_n: 1'b1,
		timeout_status: 1'b1,
		powerdown_status: 1'b1,
		brownout_mode_cfg: RST_BOR_MODE,
		stack_error_reset_enable: RST_STACK_ERROR_RESET_ENABLE,
		saf_enable: RST_SAF_EN,
		dev_reset: 1'b0,
		pc_load: 1'b0,
		pc_addr: 15'h0000,
		irq_woke: 1'b0,
		wake: WAKE_IDLE
	};

	localparam logic [14:0] PROG_LIMIT = 15'(PROG_WORDS);
	localparam logic [14:0] SAF_START = 15'(SAF_BASE);

	state_s st_r;
	state_s st_nxt;

	logic bus_req;
	logic bus_take;
	logic [11:0] reg_idx;
	logic wr_byte0;
	logic pin_fall;
	logic pin_low;
	logic wdt_reset;
	logic wdt_wake;
	logic int_wake;
	logic mem_violation;
	logic stk_reset;
	logic any_reset;
	logic bor_en;
	logic [7:0] rd_byte;

	// ************************************************************
	// Combinational next state.
	// ************************************************************
	always_comb
	begin
		st_nxt = st_r;

		// Synchronisers: the first stage feeds only the second.
		st_nxt.pin_sync = {st_r.pin_sync[0], external_reset_pin_n};
		st_nxt.pin_prev = st_r.pin_sync[1];
		st_nxt.rdy_sync = {st_r.rdy_sync[0], brownout_ready_raw};

		// One wait cycle per access; the request is taken on the second.
		bus_req = read | write;
		bus_take = bus_req & st_r.ack;
		st_nxt.ack = bus_req & ~st_r.ack;
		reg_idx = address[13:2];
		wr_byte0 = write & bus_take & byteenable[0];

		pin_low = ~st_r.pin_sync[1];
		pin_fall = st_r.pin_prev & ~st_r.pin_sync[1];
		wdt_reset = watchdog_timeout & ~sleep_active;
		wdt_wake = watchdog_timeout & sleep_active;
		int_wake = irq_wake & sleep_active;

		// A fetch counts only when it is executed, not when prefetched.
		mem_violation = fetch_exec & ((fetch_addr >= PROG_LIMIT) |
			(st_r.saf_enable & (fetch_addr >= SAF_START)));

		stk_reset = (stack_overflow_evt | stack_underflow_evt) &
			st_r.stack_error_reset_enable;

		unique case (st_r.brownout_mode_cfg)
			BOR_MODE_ON: bor_en = 1'b1;
			BOR_MODE_NOSLEEP: bor_en = ~sleep_active;
			BOR_MODE_SW: bor_en = st_r.sw_brownout_enable;
			default: bor_en = 1'b0;
		endcase

		// Register read path, captured during the wait cycle.
		rd_byte = 8'h00;
		unique case (reg_idx)
			IDX_BROWNOUT_CONTROL:
			begin
				rd_byte[BIT_SW_BOR_EN] = st_r.sw_brownout_enable;
				rd_byte[BIT_BOR_READY] = bor_en & st_r.rdy_sync[1];
			end
			IDX_RESET_CAUSE:
			begin
				rd_byte[BIT_STK_OVF] = st_r.stack_overflow_flag;
				rd_byte[BIT_STK_UNF] = st_r.stack_underflow_flag;
				rd_byte[BIT_WDT_N] = st_r.watchdog_reset_flag_n;
				rd_byte[BIT_PIN_N] = st_r.pin_reset_flag_n;
				rd_byte[BIT_INSTR_N] = st_r.instr_reset_flag_n;
				rd_byte[BIT_POR_N] = st_r.por_flag_n;
				rd_byte[BIT_BOR_N] = st_r.brownout_flag_n;
			end
			IDX_VIOLATION_CAUSE:
				rd_byte[BIT_MEM_VIOLATION_FLAG_N_N] = st_r.mem_violation_flag_n;
			IDX_CORE_STATUS:
			begin
				rd_byte[BIT_TIMEOUT] = st_r.timeout_status;
				rd_byte[BIT_POWERDOWN] = st_r.powerdown_status;
			end
			IDX_RESET_CONFIG:
			begin
				rd_byte[BIT_CFG_MODE_LO +: 2] = st_r.brownout_mode_cfg;
				rd_byte[BIT_CFG_STACK_ERROR_RESET_ENABLE] = st_r.stack_error_reset_enable;
				rd_byte[BIT_CFG_SAF_EN] = st_r.saf_enable;
			end
			default: rd_byte = 8'h00;
		endcase
		st_nxt.rdata = (read & ~st_r.ack) ? {24'h00_0000, rd_byte} :
			st_r.rdata;

		// Software writes come first so that hardware events override them.
		// Writing a flag active only stores it; no reset is raised.
		if (wr_byte0)
		begin
			unique case (reg_idx)
				IDX_BROWNOUT_CONTROL:
					st_nxt.sw_brownout_enable = writedata[BIT_SW_BOR_EN];
				IDX_RESET_CAUSE:
				begin
					st_nxt.stack_overflow_flag = writedata[BIT_STK_OVF];
					st_nxt.stack_underflow_flag = writedata[BIT_STK_UNF];
					st_nxt.watchdog_reset_flag_n = writedata[BIT_WDT_N];
					st_nxt.pin_reset_flag_n = writedata[BIT_PIN_N];
					st_nxt.instr_reset_flag_n = writedata[BIT_INSTR_N];
					st_nxt.por_flag_n = writedata[BIT_POR_N];
					st_nxt.brownout_flag_n = writedata[BIT_BOR_N];
				end
				IDX_VIOLATION_CAUSE:
					st_nxt.mem_violation_flag_n = writedata[BIT_MEM_VIOLATION_FLAG_N_N];
				IDX_RESET_CONFIG:
				begin
					st_nxt.brownout_mode_cfg = writedata[BIT_CFG_MODE_LO +: 2];
					st_nxt.stack_error_reset_enable = writedata[BIT_CFG_STACK_ERROR_RESET_ENABLE];
					st_nxt.saf_enable = writedata[BIT_CFG_SAF_EN];
				end
				default:
				begin
					st_nxt.saf_enable = st_r.saf_enable;
				end
			endcase
		end

		// Hardware updates: each cause touches only its own bits.
		if (stack_overflow_evt)
			st_nxt.stack_overflow_flag = 1'b1;
		if (stack_underflow_evt)
			st_nxt.stack_underflow_flag = 1'b1;
		if (wdt_reset)
		begin
			st_nxt.watchdog_reset_flag_n = 1'b0;
			st_nxt.timeout_status = 1'b0;
		end
		if (wdt_wake)
		begin
			st_nxt.timeout_status = 1'b0;
			st_nxt.powerdown_status = 1'b0;
		end
		if (int_wake)
		begin
			st_nxt.timeout_status = 1'b1;
			st_nxt.powerdown_status = 1'b0;
		end
		if (pin_fall)
		begin
			st_nxt.pin_reset_flag_n = 1'b0;
			if (sleep_active)
			begin
				st_nxt.timeout_status = 1'b1;
				st_nxt.powerdown_status = 1'b0;
			end
		end
		if (reset_instr)
			st_nxt.instr_reset_flag_n = 1'b0;
		if (mem_violation)
			st_nxt.mem_violation_flag_n = 1'b0;

		// Supply events restore the flag, status and enable defaults; they outrank all else.
		if (por_event | bor_event)
		begin
			st_nxt.stack_overflow_flag = 1'b0;
			st_nxt.stack_underflow_flag = 1'b0;
			st_nxt.watchdog_reset_flag_n = 1'b1;
			st_nxt.pin_reset_flag_n = 1'b1;
			st_nxt.instr_reset_flag_n = 1'b1;
			st_nxt.mem_violation_flag_n = 1'b1;
			st_nxt.sw_brownout_enable = 1'b1;
			st_nxt.timeout_status = 1'b1;
			st_nxt.powerdown_status = 1'b1;
			if (bor_event)
				st_nxt.brownout_flag_n = 1'b0;
			if (por_event)
				st_nxt.por_flag_n = 1'b0;
		end

		// ********************************************************
		// Reset request and program counter loading.
		// ********************************************************
		any_reset = por_event | bor_event | pin_fall | wdt_reset |
			reset_instr | stk_reset | mem_violation;
		// The pin holds the device in reset for as long as it stays low.
		st_nxt.dev_reset = any_reset | pin_low;
		st_nxt.pc_load = 1'b0;
		st_nxt.pc_addr = st_r.pc_addr;

		unique case (st_r.wake)
			WAKE_IDLE:
			begin
				if (wdt_wake | int_wake)
				begin
					st_nxt.wake = WAKE_RESUME;
					st_nxt.irq_woke = int_wake;
				end
			end
			WAKE_RESUME:
			begin
				// Only an interrupt wake may enter the vector.
				st_nxt.wake = (global_irq_enable & st_r.irq_woke) ?
					WAKE_VECTOR : WAKE_IDLE;
			end
			WAKE_VECTOR:
			begin
				st_nxt.wake = WAKE_IDLE;
				st_nxt.pc_load = 1'b1;
				st_nxt.pc_addr = IRQ_VECTOR;
			end
			default: st_nxt.wake = WAKE_IDLE;
		endcase

		// A true reset aborts any wake sequence in flight.
		if (any_reset)
		begin
			st_nxt.wake = WAKE_IDLE;
			st_nxt.pc_load = 1'b1;
			st_nxt.pc_addr = RESET_VECTOR;
		end
	end

	// ************************************************************
	// State register.
	// ************************************************************
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			st_r <= ST_RESET;
		else
			st_r <= st_nxt;
	end

	// ************************************************************
	// Outputs.
	// ************************************************************
	assign waitrequest = bus_req & ~st_r.ack;
	assign readdata = st_r.rdata;
	assign brownout_detect_en = bor_en;
	assign device_reset = st_r.dev_reset;
	assign pc_load = st_r.pc_load;
	assign pc_load_addr = st_r.pc_addr;
	assign wake_resume = (st_r.wake == WAKE_RESUME);
	assign irq_push = (st_r.wake == WAKE_VECTOR);
	assign timeout_status = st_r.timeout_status;
	assign powerdown_status = st_r.powerdown_status;

endmodule // reset_cause_flags

/* reset_cause_checker.sv */
// Assertions on the reset-cause block, bound to its top module.
// Assumes sources are one-cycle pulses and rst is the only block reset.
module reset_cause_checker
	import reset_cause_pkg::*;
#(
	parameter int PROG_WORDS = 4096
)
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Sources.
	input wire logic por_event,
	input wire logic external_reset_pin_n,
	input wire logic watchdog_timeout,
	input wire logic reset_instr,
	input wire logic fetch_exec,
	input wire logic [14:0] fetch_addr,
	input wire logic sleep_active,
	input wire logic irq_wake,
	input wire logic global_irq_enable,
	// Results.
	input wire logic device_reset,
	input wire logic pc_load,
	input wire logic [14:0] pc_load_addr,
	input wire logic wake_resume,
	input wire logic irq_push,
	input wire logic timeout_status,
	input wire logic powerdown_status
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// Properties
	// ********
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	property p_mv;
		fetch_exec && fetch_addr >= PROG_WORDS |=>
			device_reset && pc_load && pc_load_addr == RESET_VECTOR;
	endproperty
	a_mv: assert property (p_mv) else $error("no mv reset");
	property p_ri;
		reset_instr |=> device_reset && pc_load;
	endproperty
	a_ri: assert property (p_ri) else $error("no instr reset");
	property p_wd;
		watchdog_timeout && !sleep_active |=> device_reset && !timeout_status;
	endproperty
	a_wd: assert property (p_wd) else $error("bad wdt reset");
	property p_ww;
		watchdog_timeout && sleep_active |=>
			!device_reset && !timeout_status && !powerdown_status;
	endproperty
	a_ww: assert property (p_ww) else $error("wdt wake");
	property p_iw;
		irq_wake && sleep_active |=>
			wake_resume && timeout_status && !powerdown_status;
	endproperty
	a_iw: assert property (p_iw) else $error("irq wake");
	property p_vec;
		irq_wake && sleep_active ##1 wake_resume && global_irq_enable |=>
			irq_push ##1 (pc_load && pc_load_addr == IRQ_VECTOR);
	endproperty
	a_vec: assert property (p_vec) else $error("no vector");
	property p_wwv;
		watchdog_timeout && sleep_active && !irq_wake |=>
			wake_resume ##1 !irq_push;
	endproperty
	a_wwv: assert property (p_wwv) else $error("wake vectored");
	property p_por;
		por_event |=> device_reset && timeout_status && powerdown_status;
	endproperty
	a_por: assert property (p_por) else $error("power-on");
	property p_pin;
		$fell(external_reset_pin_n) |-> ##[2:4] device_reset;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset");

	c_vec: cover property (irq_push);
	c_pin: cover property ($fell(external_reset_pin_n));
	c_mv: cover property (fetch_exec && fetch_addr >= PROG_WORDS);
endmodule // reset_cause_checker

bind reset_cause_flags reset_cause_checker #(.PROG_WORDS(PROG_WORDS)) u_chk (
	.clock, .rst, .por_event, .external_reset_pin_n, .watchdog_timeout,
	.reset_instr, .fetch_exec, .fetch_addr, .sleep_active, .irq_wake,
	.global_irq_enable, .device_reset, .pc_load, .pc_load_addr,
	.wake_resume, .irq_push, .timeout_status, .powerdown_status
);

/* core_source_model.sv */
// Model of the core and on-chip reset sources feeding the block.
// Assumes fire is called just after a rising clock edge.
module core_source_model
(
	// Clock.
	input wire logic clock,
	// Event pulses and fetch address.
	output logic watchdog_timeout,
	output logic reset_instr,
	output logic stack_overflow_evt,
	output logic stack_underflow_evt,
	output logic fetch_exec,
	output logic bor_event,
	output logic por_event,
	output logic irq_wake,
	output logic [14:0] fetch_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ev_r = 8'h00;

	assign {irq_wake, por_event, bor_event, fetch_exec} = ev_r[7:4];
	assign {stack_underflow_evt, stack_overflow_evt} = ev_r[3:2];
	assign {reset_instr, watchdog_timeout} = ev_r[1:0];
	initial fetch_addr = 15'h0000;

	// A held level would count as repeated events, so pulses last one cycle.
	// The address is inverted afterwards so a stale value is never trusted.
	task automatic fire(input int k, input logic [14:0] a);
		ev_r <= 8'h01 << k;
		fetch_addr <= a;
		@(posedge clock);
		ev_r <= 8'h00;
		fetch_addr <= ~a;
	endtask
endmodule // core_source_model

/* reset_cause_flags_tb_top.sv */
// Self-checking bench for the reset-cause block.
// Assumes the core model drives event pulses; registers go over Avalon-MM.
module reset_cause_flags_tb_top
	import reset_cause_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [13:0] address = 14'h0000;
	logic read = 1'b0, write = 1'b0;
	logic [31:0] writedata = 32'h0, readdata, q;
	logic [3:0] byteenable = 4'hF;
	logic external_reset_pin_n = 1'b1, sleep_active = 1'b0;
	logic global_irq_enable = 1'b1, brownout_ready_raw = 1'b1;
	logic waitrequest, device_reset, pc_load, wake_resume, irq_push;
	logic brownout_detect_en, timeout_status, powerdown_status;
	logic por_event, bor_event, watchdog_timeout, reset_instr;
	logic stack_overflow_evt, stack_underflow_evt, fetch_exec, irq_wake;
	logic [14:0] fetch_addr, pc_load_addr, fa;
	logic [31:0] lfsr = 32'hED5321DC;
	logic [31:0] rv [6] = '{32'h81, 32'h00, 32'h1D, 32'h02, 32'h03, 32'h05};
	int errors = 0, n_checks = 0, c, v, sb, k;

	always #25 clock = ~clock;

	reset_cause_flags uut (.clock, .rst, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .por_event, .bor_event,
		.external_reset_pin_n, .watchdog_timeout, .reset_instr,
		.stack_overflow_evt, .stack_underflow_evt, .fetch_exec, .fetch_addr,
		.sleep_active, .irq_wake, .global_irq_enable, .brownout_ready_raw,
		.brownout_detect_en, .device_reset, .pc_load, .pc_load_addr,
		.wake_resume, .irq_push, .timeout_status, .powerdown_status);
	core_source_model core (.clock, .watchdog_timeout, .reset_instr,
		.stack_overflow_evt, .stack_underflow_evt, .fetch_exec, .bor_event,
		.por_event, .irq_wake, .fetch_addr);

	// ********
	// Tasks
	// ********
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [11:0] idx,
		input logic [7:0] d);
		int i;
		address <= {idx, 2'b00};
		write <= w;
		read <= !w;
		writedata <= {24'h0, d};
		for (i = 0; i < 20; i++)
		begin
			@(posedge clock);
			if (waitrequest === 1'b0)
				break;
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (i == 20)
		begin
			errors++;
			close_out;
		end
		@(posedge clock);
	endtask

	// Reference flag model: clears or sets only the bit of the cause, except brown-out and power-on, which also restore the other defaults.
	task automatic apply(input int k);
		case (k)
			0: c = c & ~16;
			1: c = c & ~4;
			2: c = c | 128;
			3: c = c | 64;
			4: v = 0;
			5, 6:
			begin
				c = (c & (k == 5 ? 2 : 1)) | 28;
				v = 2;
				sb = 1;
			end
			8: c = c & ~8;
			default: ;
		endcase
	endtask

	// ********
	// Sequence
	// ********
	initial
	begin
		#2000000;
		errors++;
		close_out;
	end

	initial
	begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		for (k = 0; k < 6; k++)
		begin
			bus(0, IDX_BROWNOUT_CONTROL + 12'(k), 8'h00);
			chk("reset value", rv[k], q);
		end
		$display("test reset values done");
		for (k = 0; k < 10; k++)
		begin
			bus(1, IDX_RESET_CAUSE, 8'h1F);
			bus(1, IDX_VIOLATION_CAUSE, 8'h02);
			bus(1, IDX_BROWNOUT_CONTROL, 8'h00);
			c = 31;
			v = 2;
			sb = 0;
			lfsr = nx(lfsr);
			fa = (k == 4) ? 15'(4096 + lfsr % 28672) : 15'(lfsr % 3968);
			if (k == 8)
			begin
				external_reset_pin_n <= 1'b0;
				repeat (6) @(posedge clock);
				external_reset_pin_n <= 1'b1;
			end
			else
			begin
				core.fire(k == 9 ? 4 : k, fa);
				@(posedge clock);
				chk("device reset", 32'(k < 7), 32'(device_reset));
			end
			repeat (8) @(posedge clock);
			apply(k);
			bus(0, IDX_RESET_CAUSE, 8'h00);
			chk("cause flags", 32'(c), q);
			bus(0, IDX_VIOLATION_CAUSE, 8'h00);
			chk("violation flag", 32'(v), q);
			bus(0, IDX_BROWNOUT_CONTROL, 8'h00);
			chk("brownout control", sb ? 32'h81 : 32'h00, q);
		end
		$display("test reset sources done");
		for (k = 0; k < 3; k++)
		begin
			lfsr = nx(lfsr);
			bus(1, IDX_RESET_CAUSE, lfsr[7:0]);
			chk("reset on write", 32'h0, 32'(device_reset));
			bus(0, IDX_RESET_CAUSE, 8'h00);
			chk("written flags", {24'h0, lfsr[7:0] & 8'hDF}, q);
		end
		bus(1, 12'h812, 8'hFF);
		bus(0, 12'h812, 8'h00);
		chk("unmapped", 32'h0, q);
		$display("test software writes done");
		bus(1, IDX_BROWNOUT_CONTROL, 8'h80);
		chk("detect enable", 32'h1, 32'(brownout_detect_en));
		bus(1, IDX_RESET_CONFIG, 8'h04);
		chk("detect enable", 32'h0, 32'(brownout_detect_en));
		bus(0, IDX_BROWNOUT_CONTROL, 8'h00);
		chk("brownout control", 32'h80, q);
		bus(1, IDX_RESET_CONFIG, 8'h07);
		chk("detect enable", 32'h1, 32'(brownout_detect_en));
		bus(1, IDX_RESET_CONFIG, 8'h06);
		chk("detect enable", 32'h1, 32'(brownout_detect_en));
		bus(1, IDX_RESET_CONFIG, 8'h05);
		bus(1, IDX_BROWNOUT_CONTROL, 8'h00);
		chk("detect enable", 32'h0, 32'(brownout_detect_en));
		$display("test brownout enable done");
		sleep_active <= 1'b1;
		core.fire(7, 15'h0000);
		repeat (6) @(posedge clock);
		bus(0, IDX_CORE_STATUS, 8'h00);
		chk("status after irq wake", 32'h02, q);
		core.fire(0, 15'h0000);
		repeat (6) @(posedge clock);
		bus(0, IDX_CORE_STATUS, 8'h00);
		chk("status after watchdog wake", 32'h00, q);
		bus(0, IDX_RESET_CAUSE, 8'h00);
		chk("flags after wake", {24'h0, lfsr[7:0] & 8'hDF}, q);
		bus(1, IDX_RESET_CONFIG, 8'h06);
		chk("detect enable", 32'h0, 32'(brownout_detect_en));
		bus(1, IDX_RESET_CONFIG, 8'h05);
		c = lfsr[7:0] & 8'hD7;
		external_reset_pin_n <= 1'b0;
		repeat (6) @(posedge clock);
		external_reset_pin_n <= 1'b1;
		repeat (6) @(posedge clock);
		bus(0, IDX_CORE_STATUS, 8'h00);
		chk("status after pin in sleep", 32'h02, q);
		bus(0, IDX_RESET_CAUSE, 8'h00);
		chk("cause flags", 32'(c), q);
		sleep_active <= 1'b0;
		$display("test wake done");
		bus(1, IDX_VIOLATION_CAUSE, 8'h02);
		bus(1, IDX_RESET_CONFIG, 8'h09);
		lfsr = nx(lfsr);
		core.fire(4, 15'(3968 + lfsr % 128));
		@(posedge clock);
		chk("device reset", 32'h1, 32'(device_reset));
		bus(0, IDX_VIOLATION_CAUSE, 8'h00);
		chk("violation flag", 32'h0, q);
		core.fire(2, 15'h0000);
		@(posedge clock);
		chk("device reset", 32'h0, 32'(device_reset));
		bus(0, IDX_RESET_CAUSE, 8'h00);
		chk("cause flags", 32'(c | 128), q);
		$display("test protected flash and stack enable done");
		close_out;
	end
endmodule // reset_cause_flags_tb_top
